// File: sim/rxeq_props.sv
// checker for the receive-port register slice, port 0 lanes watched
// assumes a bind onto rxeq_regs, single mclk domain
`timescale 1ns/1ps
`default_nettype none
module rxeq_props
    import rxeq_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire rxeq_bus_s bus,
    input wire logic [7:0] reg_rdata,
    input wire logic raw_mode,
    input wire logic [NPORT-1:0] frame_active_signal,
    input wire logic [NPORT-1:0] frame_begin_packet,
    input wire logic [NPORT-1:0] enc_pkt_valid,
    input wire logic [NPORT-1:0] enc_pkt_crc_ok,
    input wire logic [NPORT-1:0][7:0] enc_pkt_info,
    input wire logic [NPORT-1:0][7:0] link_info,
    input wire logic crc_check_en,
    input wire logic [NGPIO-1:0] gpio_output_mode,
    input wire logic [NGPIO-1:0] pulldown_en,
    input wire logic [NPORT-1:0] remote_selftest_active,
    input wire logic local_selftest,
    input wire logic [NPORT-1:0] selftest_mismatch,
    input wire logic [NPORT-1:0] bc_frame_start,
    input wire logic [NPORT-1:0] bc_error_insert
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    sequence s_crc_wr;
        bus.wr && bus.addr == 8'hba;
    endsequence
    sequence s_pkt_kept;
        enc_pkt_valid[0] && (enc_pkt_crc_ok[0] || !crc_check_en);
    endsequence
    a_crc_gate: assert property (s_crc_wr |=> crc_check_en == !$past(bus.wdata[7]))
        else $error("crc enable does not follow its bit");
    a_pkt_kept: assert property (s_pkt_kept |=> link_info[0] == $past(enc_pkt_info[0]))
        else $error("good packet not stored");
    a_pkt_dropped: assert property (enc_pkt_valid[0] && !enc_pkt_crc_ok[0] && crc_check_en |=> $stable(link_info[0]))
        else $error("failed packet changed link info");
    a_pull_off: assert property (1'b1 |=> (pulldown_en & $past(gpio_output_mode)) == '0)
        else $error("pulldown on an output pin");
    a_selftest_err: assert property (remote_selftest_active[0] && !local_selftest |=> selftest_mismatch[0])
        else $error("selftest mismatch missed");
    a_insert_cause: assert property (bc_error_insert[0] |-> $past(bc_frame_start[0]))
        else $error("error insert without frame");
    a_frame_cause: assert property (frame_begin_packet[0] |-> $past(raw_mode && frame_active_signal[0]))
        else $error("frame begin outside raw active");
    a_rerun_clear: assert property (bus.rd && bus.addr == 8'hd2 |=> reg_rdata[3] == 1'b0)
        else $error("rerun bit reads one");
    a_const_read: assert property (bus.rd && bus.addr == 8'hd1 |=> reg_rdata == 8'h43)
        else $error("constant register changed");
endmodule : rxeq_props
`default_nettype wire

// File: sim/rxeq_remote_model.sv
// remote serializer model: encoded packets, lock and self-test level
// assumes the bench calls its tasks from the mclk domain
`timescale 1ns/1ps
`default_nettype none
module rxeq_remote_model
    import rxeq_pkg::*;
(
    input wire logic mclk,
    output logic [NPORT-1:0] enc_pkt_valid,
    output logic [NPORT-1:0] enc_pkt_crc_ok,
    output logic [NPORT-1:0][7:0] enc_pkt_info,
    output logic [NPORT-1:0] remote_selftest_active,
    output logic [NPORT-1:0] rx_lock
);
    initial begin
        enc_pkt_valid = '0;
        enc_pkt_crc_ok = '0;
        enc_pkt_info = '0;
        remote_selftest_active = '0;
        rx_lock = '0;
    end
    // idle data flips so a stale value never looks valid
    task automatic send(input int p, input logic ok, input logic [7:0] d);
        @(posedge mclk);
        enc_pkt_valid[p] <= 1'b1;
        enc_pkt_crc_ok[p] <= ok;
        enc_pkt_info[p] <= d;
        @(posedge mclk);
        enc_pkt_valid[p] <= 1'b0;
        enc_pkt_crc_ok[p] <= ~ok;
        enc_pkt_info[p] <= ~d;
    endtask : send
    task automatic set_link(input int p, input logic lk, input logic st);
        @(posedge mclk);
        rx_lock[p] <= lk;
        remote_selftest_active[p] <= st;
    endtask : set_link
endmodule : rxeq_remote_model
`default_nettype wire

// File: sim/tb_top.sv
// directed bench for the register slice with a remote serializer model
// assumes a short equalizer wait parameter
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; $display("BAD %0t got %h exp %h", $time, a, e); end end
module tb_top;
    import rxeq_pkg::*;
    localparam int WAITC = 4;
    logic mclk = 1'b0, rst_n = 1'b0, rx_port_sel = 1'b0, raw_mode = 1'b0, local_selftest = 1'b0, crc_check_en;
    rxeq_bus_s bus = '0;
    logic [7:0] reg_rdata, rv;
    logic [NPORT-1:0] frame_active_signal = '0, bc_frame_start = '0, frame_begin_packet, enc_pkt_valid;
    logic [NPORT-1:0] enc_pkt_crc_ok, remote_selftest_active, selftest_mismatch, bc_error_insert, rx_lock;
    logic [NPORT-1:0][7:0] enc_pkt_info, link_info;
    logic [NGPIO-1:0] gpio_output_mode = '0, pulldown_en;
    logic [NPORT-1:0][3:0] eq_floor_level = {4'h2, 4'h2}, eq_ceiling = {4'hf, 4'hf};
    logic [NPORT-1:0][5:0] eq_level;
    int fail_count = 0, n_compared = 0, n;
    rxeq_regs #(.EQ_WAIT_CYCLES(WAITC)) rxeq_regs_inst (.*);
    rxeq_remote_model rxeq_remote_model_inst (.*);
    always #5 mclk = ~mclk;
    // ------------------------------------------------------------
    // bus and wait helpers
    // ------------------------------------------------------------
    task automatic wr(input logic p, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        rx_port_sel <= p;
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic p, input logic [7:0] a);
        @(posedge mclk);
        rx_port_sel <= p;
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        @(negedge mclk);
        rv = reg_rdata;
    endtask : rd
    task automatic wait_lvl(input logic [5:0] v);
        n = 0;
        while (eq_level[0] !== v) begin
            @(negedge mclk);
            n++;
            if (n > 300) begin
                fail_count++;
                end_of_test;
            end
        end
    endtask : wait_lvl
    task automatic bc(input logic [1:0] e);
        @(posedge mclk);
        bc_frame_start <= 2'b11;
        @(posedge mclk);
        bc_frame_start <= 2'b00;
        @(negedge mclk);
        `CHK(bc_error_insert, e)
    endtask : bc
    task automatic end_of_test;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_defaults;
        logic [7:0] a[11] = '{8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hbf, 8'hd0, 8'hd1, 8'hd2, 8'h00, 8'hd3};
        logic [7:0] e[11] = '{8'h03, 8'h74, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h43, 8'h94, 8'h00, 8'h02};
        `CHK(crc_check_en, 1'b1)
        for (int i = 0; i < 11; i++) begin
            rd(1'b0, a[i]);
            `CHK(rv, e[i])
        end
    endtask : t_defaults
    task automatic t_access;
        wr(1'b0, 8'hbe, 8'hff);
        rd(1'b0, 8'hbe);
        `CHK(rv, 8'h7f)
        `CHK(pulldown_en, 7'h00)
        @(posedge mclk);
        gpio_output_mode <= 7'h05;
        wr(1'b0, 8'hbe, 8'h00);
        repeat (2) @(negedge mclk);
        `CHK(pulldown_en, 7'h7a)
        wr(1'b0, 8'hd1, 8'hff);
        rd(1'b0, 8'hd1);
        `CHK(rv, 8'h43)
        wr(1'b0, 8'hd2, 8'hff);
        rd(1'b0, 8'hd2);
        `CHK(rv, 8'hf4)
    endtask : t_access
    task automatic t_crc;
        rxeq_remote_model_inst.send(0, 1'b1, 8'ha5);
        @(negedge mclk);
        `CHK(link_info[0], 8'ha5)
        rxeq_remote_model_inst.send(0, 1'b0, 8'h3c);
        @(negedge mclk);
        `CHK(link_info[0], 8'ha5)
        wr(1'b0, 8'hba, 8'h83);
        @(negedge mclk);
        `CHK(crc_check_en, 1'b0)
        rxeq_remote_model_inst.send(0, 1'b0, 8'h3c);
        @(negedge mclk);
        `CHK(link_info[0], 8'h3c)
        wr(1'b0, 8'hba, 8'h03);
    endtask : t_crc
    task automatic t_frame;
        for (int k = 0; k < 2; k++) begin
            wr(1'b0, 8'hbc, 8'(k * 3));
            @(posedge mclk);
            raw_mode <= 1'b1;
            frame_active_signal <= 2'b01;
            n = 0;
            do begin
                @(negedge mclk);
                n++;
            end while (frame_begin_packet[0] !== 1'b1 && n < 20);
            `CHK(n, k * 3 + 2)
            @(negedge mclk);
            `CHK(frame_begin_packet[0], 1'b0)
            @(posedge mclk);
            frame_active_signal <= 2'b00;
        end
        @(posedge mclk);
        raw_mode <= 1'b0;
        frame_active_signal <= 2'b01;
        repeat (6) @(negedge mclk);
        `CHK(frame_begin_packet, 2'b00)
        @(posedge mclk);
        frame_active_signal <= 2'b00;
    endtask : t_frame
    task automatic t_inject;
        wr(1'b1, 8'hd0, 8'h01);
        bc(2'b10);
        bc(2'b00);
        wr(1'b1, 8'hd0, 8'h02);
        bc(2'b10);
        bc(2'b10);
        wr(1'b1, 8'hd0, 8'h00);
        rxeq_remote_model_inst.set_link(1, 1'b0, 1'b1);
        rd(1'b1, 8'hd0);
        `CHK(rv, 8'h20)
        `CHK(selftest_mismatch, 2'b10)
        rd(1'b0, 8'hd0);
        `CHK(rv, 8'h00)
        wr(1'b0, 8'hd0, 8'h01);
        bc(2'b01);
        rxeq_remote_model_inst.set_link(0, 1'b0, 1'b1);
        repeat (2) @(negedge mclk);
        `CHK(selftest_mismatch, 2'b11)
        @(posedge mclk);
        local_selftest <= 1'b1;
        repeat (2) @(negedge mclk);
        `CHK(selftest_mismatch, 2'b00)
        rxeq_remote_model_inst.set_link(0, 1'b0, 1'b0);
    endtask : t_inject
    task automatic t_eq;
        wr(1'b0, 8'hd2, 8'h1c);
        repeat (3) @(negedge mclk);
        `CHK(eq_level[0], 6'h02)
        wait_lvl(6'h03);
        wait_lvl(6'h04);
        `CHK(n, WAITC)
        wr(1'b0, 8'hd2, 8'h34);
        wait_lvl(6'h05);
        wait_lvl(6'h06);
        `CHK(n, 2 * WAITC)
        rxeq_remote_model_inst.set_link(0, 1'b1, 1'b0);
        repeat (20) @(negedge mclk);
        `CHK(eq_level[0], 6'h00)
        rd(1'b0, 8'hd3);
        `CHK(rv, 8'h00)
        rxeq_remote_model_inst.set_link(0, 1'b0, 1'b0);
        eq_floor_level[0] <= 4'h5;
        wr(1'b0, 8'hd2, 8'h1c);
        repeat (3) @(negedge mclk);
        `CHK(eq_level[0], 6'h05)
        wr(1'b0, 8'hd2, 8'h18);
        repeat (3) @(negedge mclk);
        `CHK(eq_level[0], 6'h00)
        @(posedge mclk);
        eq_ceiling[0] <= 4'h1;
        wait_lvl(6'h01);
        wait_lvl(6'h00);
        `CHK(n, WAITC)
        wr(1'b1, 8'hd2, 8'h0c);
        rxeq_remote_model_inst.set_link(1, 1'b1, 1'b1);
        repeat (8) @(negedge mclk);
        `CHK(eq_level[1], 6'h02)
        rd(1'b1, 8'hd3);
        `CHK(rv, 8'h02)
    endtask : t_eq
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        t_defaults;
        t_access;
        t_crc;
        t_frame;
        t_inject;
        t_eq;
        end_of_test;
    end
endmodule : tb_top
bind rxeq_regs rxeq_props rxeq_props_inst (.*);
`default_nettype wire

// File: verilog/rxeq_pkg.sv
// constants, field layout and bus carrier for the receive-port equalizer and debug register slice
// assumes an upstream i2c target decodes transfers into one-cycle register strobes on mclk
//
// Operation
// - crc disable bit clear enables encoder crc
// - failed-crc packets update link information only while crc checking is disabled
// - raw mode frame begin after minimum active
// - pulldown on whenever pin not output and its disable bit clear
// - per-pin disable bit turns pulldown off
// - read-only remote self-test flag, bit five
// - continuous bit injects error every reverse frame
// - one-shot bit injects error into one frame
// - lock wait 164us doubling per code step
// - policy bit: first lock restarts from zero
// - rerun bit restarts adaptation, clears itself
// - floor-start enable begins adaptation at floor
// - port select routes per-port register accesses
// - floor start value from floor level field
package rxeq_pkg;

    localparam int NPORT = 2;
    localparam int NGPIO = 7;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_ENC_CTL = 8'hba;
    localparam logic [7:0] OFS_RSVD_BB = 8'hbb;
    localparam logic [7:0] OFS_FA_MIN = 8'hbc;
    localparam logic [7:0] OFS_RSVD_BD = 8'hbd;
    localparam logic [7:0] OFS_PD_CTL = 8'hbe;
    localparam logic [7:0] OFS_RSVD_BF = 8'hbf;
    localparam logic [7:0] OFS_DEBUG = 8'hd0;
    localparam logic [7:0] OFS_RSVD_D1 = 8'hd1;
    localparam logic [7:0] OFS_EQ_CTL2 = 8'hd2;
    localparam logic [7:0] OFS_EQ_STS = 8'hd3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ENC_CTL = 8'h03;
    localparam logic [7:0] RST_RSVD_BB = 8'h74;
    localparam logic [7:0] RST_FA_MIN = 8'h00;
    localparam logic [7:0] RST_RSVD_BD = 8'h00;
    localparam logic [6:0] RST_PD_CTL = 7'h00;
    localparam logic [7:0] RST_RSVD_BF = 8'h00;
    localparam logic [7:0] RST_DEBUG = 8'h00;
    localparam logic [7:0] RST_RSVD_D1 = 8'h43;
    localparam logic [7:0] RST_EQ_CTL2 = 8'h94;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CRC_DIS_BIT = 7;
    localparam int SELFTEST_BIT = 5;
    localparam int INJ_CONT_BIT = 1;
    localparam int INJ_ONCE_BIT = 0;
    localparam int WAIT_SEL_LSB = 5;
    localparam int FIRST_LOCK_BIT = 4;
    localparam int RERUN_BIT = 3;
    localparam int FLOOR_EN_BIT = 2;
    localparam logic [7:0] DEBUG_RW_MASK = 8'hdf;
    localparam logic [7:0] EQ_CTL2_RW_MASK = 8'hf4;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int EQ_WAIT_BASE_US = 164;
    localparam int EQ_WAIT_BASE_CYCLES = (EQ_WAIT_BASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EQ_TIMER_W = 24;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rxeq_bus_s;

    typedef enum logic [1:0] {
        EQ_START,
        EQ_WAIT,
        EQ_LOCKED
    } rxeq_eq_e;

endpackage : rxeq_pkg

// File: verilog/rxeq_regs.sv
// register slice: encoder crc gate, raw frame-begin timing, pulldowns,
// reverse-channel error injection and adaptive equalizer per receive port
// assumes bus strobes, port select and all link inputs are synchronous to mclk
`timescale 1ns/1ps
`default_nettype none

module rxeq_regs
    import rxeq_pkg::*;
#(
    parameter int EQ_WAIT_CYCLES = EQ_WAIT_BASE_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire rxeq_bus_s bus,
    input wire logic rx_port_sel,
    output logic [7:0] reg_rdata,
    input wire logic raw_mode,
    input wire logic [NPORT-1:0] frame_active_signal,
    output logic [NPORT-1:0] frame_begin_packet,
    input wire logic [NPORT-1:0] enc_pkt_valid,
    input wire logic [NPORT-1:0] enc_pkt_crc_ok,
    input wire logic [NPORT-1:0][7:0] enc_pkt_info,
    output logic [NPORT-1:0][7:0] link_info,
    output logic crc_check_en,
    input wire logic [NGPIO-1:0] gpio_output_mode,
    output logic [NGPIO-1:0] pulldown_en,
    input wire logic [NPORT-1:0] remote_selftest_active,
    input wire logic local_selftest,
    output logic [NPORT-1:0] selftest_mismatch,
    input wire logic [NPORT-1:0] bc_frame_start,
    output logic [NPORT-1:0] bc_error_insert,
    input wire logic [NPORT-1:0] rx_lock,
    input wire logic [NPORT-1:0][3:0] eq_floor_level,
    input wire logic [NPORT-1:0][3:0] eq_ceiling,
    output logic [NPORT-1:0][5:0] eq_level
);

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [7:0] enc_ctl;
    logic [7:0] rsvd_bb;
    logic [7:0] fa_min;
    logic [7:0] rsvd_bd;
    logic [NGPIO-1:0] pd_ctl;
    logic [7:0] rsvd_bf;
    logic [NPORT-1:0][7:0] debug_ctl;
    logic [NPORT-1:0][7:0] eq_ctl;
    logic [NPORT-1:0] port_wr;
    logic [NPORT-1:0] rerun_req;
    logic [NPORT-1:0] once_req;
    logic [7:0] next_rdata;

    // ------------------------------------------------------------
    // port routing of write strobes
    // ------------------------------------------------------------
    // one-shot and rerun act on the write itself, not on stored bits

    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            port_wr[p] = bus.wr && (rx_port_sel == p[0]);
            rerun_req[p] = port_wr[p] && (bus.addr == OFS_EQ_CTL2) && bus.wdata[RERUN_BIT];
            once_req[p] = port_wr[p] && (bus.addr == OFS_DEBUG) && bus.wdata[INJ_ONCE_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            enc_ctl <= RST_ENC_CTL;
            rsvd_bb <= RST_RSVD_BB;
            fa_min <= RST_FA_MIN;
            rsvd_bd <= RST_RSVD_BD;
            pd_ctl <= RST_PD_CTL;
            rsvd_bf <= RST_RSVD_BF;
        end else if (bus.wr) begin
            case (bus.addr)
                OFS_ENC_CTL: enc_ctl <= bus.wdata;
                OFS_RSVD_BB: rsvd_bb <= bus.wdata;
                OFS_FA_MIN: fa_min <= bus.wdata;
                OFS_RSVD_BD: rsvd_bd <= bus.wdata;
                OFS_PD_CTL: pd_ctl <= bus.wdata[NGPIO-1:0];
                OFS_RSVD_BF: rsvd_bf <= bus.wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // per-port control registers
    // ------------------------------------------------------------
    // rerun bit is never stored, so it reads zero from the write onward
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            debug_ctl <= {NPORT{RST_DEBUG}};
            eq_ctl <= {NPORT{RST_EQ_CTL2}};
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                if (port_wr[p] && bus.addr == OFS_DEBUG) begin
                    debug_ctl[p] <= bus.wdata & DEBUG_RW_MASK;
                end
                if (port_wr[p] && bus.addr == OFS_EQ_CTL2) begin
                    eq_ctl[p] <= bus.wdata & EQ_CTL2_RW_MASK;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // read path, one cycle latency
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = 8'h00;
        case (bus.addr)
            OFS_ENC_CTL: next_rdata = enc_ctl;
            OFS_RSVD_BB: next_rdata = rsvd_bb;
            OFS_FA_MIN: next_rdata = fa_min;
            OFS_RSVD_BD: next_rdata = rsvd_bd;
            OFS_PD_CTL: next_rdata = {1'b0, pd_ctl};
            OFS_RSVD_BF: next_rdata = rsvd_bf;
            OFS_DEBUG: begin
                next_rdata = debug_ctl[rx_port_sel];
                next_rdata[SELFTEST_BIT] = remote_selftest_active[rx_port_sel];
            end
            OFS_RSVD_D1: next_rdata = RST_RSVD_D1;
            OFS_EQ_CTL2: next_rdata = eq_ctl[rx_port_sel];
            OFS_EQ_STS: next_rdata = {2'b00, eq_level[rx_port_sel]};
            default: next_rdata = 8'h00;
        endcase
    end

    // a write in the same cycle is seen by the next read, not this one
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (bus.rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // encoder crc gate on link information
    // ------------------------------------------------------------
    assign crc_check_en = ~enc_ctl[CRC_DIS_BIT];

    // refused packets are dropped silently; no error is counted here

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            link_info <= '0;
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                if (enc_pkt_valid[p] && (!crc_check_en || enc_pkt_crc_ok[p])) begin
                    link_info[p] <= enc_pkt_info[p];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // raw mode frame-begin qualification
    // ------------------------------------------------------------
    logic [NPORT-1:0][7:0] fa_count;
    logic [NPORT-1:0] fa_issued;

    // count saturates so very long frames cannot wrap and re-qualify
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fa_count <= '0;
            fa_issued <= '0;
            frame_begin_packet <= '0;
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                frame_begin_packet[p] <= 1'b0;
                if (!frame_active_signal[p] || !raw_mode) begin
                    fa_count[p] <= 8'h00;
                    fa_issued[p] <= 1'b0;
                end else begin
                    if (fa_count[p] != 8'hff) begin
                        fa_count[p] <= fa_count[p] + 8'h01;
                    end
                    if (!fa_issued[p] && fa_count[p] >= fa_min) begin
                        frame_begin_packet[p] <= 1'b1;
                        fa_issued[p] <= 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // pin pulldowns
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pulldown_en <= '0;
        end else begin
            // output mode wins; disable bits only matter for input pins
            pulldown_en <= ~gpio_output_mode & ~pd_ctl;
        end
    end

    // ------------------------------------------------------------
    // self-test and reverse-channel error injection
    // ------------------------------------------------------------
    logic [NPORT-1:0] once_armed;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            selftest_mismatch <= '0;
        end else begin
            selftest_mismatch <= remote_selftest_active & {NPORT{~local_selftest}};
        end
    end

    // a new one-shot request in the consuming cycle wins and stays armed
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            once_armed <= '0;
            bc_error_insert <= '0;
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                bc_error_insert[p] <= bc_frame_start[p]
                    && (debug_ctl[p][INJ_CONT_BIT] || once_armed[p]);
                if (once_req[p]) begin
                    once_armed[p] <= 1'b1;
                end else if (bc_frame_start[p]) begin
                    once_armed[p] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // adaptive equalizer
    // ------------------------------------------------------------
    rxeq_eq_e eq_state [NPORT];
    logic [NPORT-1:0][EQ_TIMER_W-1:0] eq_timer;
    logic [NPORT-1:0][EQ_TIMER_W-1:0] eq_limit;
    logic [NPORT-1:0][5:0] eq_start;
    logic [NPORT-1:0] first_lock_seen;

    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            eq_limit[p] = EQ_WAIT_CYCLES[EQ_TIMER_W-1:0] << eq_ctl[p][WAIT_SEL_LSB +: 3];
            eq_start[p] = eq_ctl[p][FLOOR_EN_BIT] ? {2'b00, eq_floor_level[p]} : 6'h00;
        end
    end

    // stepping past the ceiling wraps to the start point; the ceiling is trusted above the floor
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int p = 0; p < NPORT; p++) begin
                eq_state[p] <= EQ_START;
            end
            eq_timer <= '0;
            eq_level <= '0;
            first_lock_seen <= '0;
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                if (rerun_req[p]) begin
                    eq_state[p] <= EQ_START;
                end else begin
                    case (eq_state[p])
                        EQ_START: begin
                            eq_level[p] <= eq_start[p];
                            eq_timer[p] <= '0;
                            eq_state[p] <= EQ_WAIT;
                        end
                        EQ_WAIT: begin
                            if (rx_lock[p]) begin
                                first_lock_seen[p] <= 1'b1;
                                eq_timer[p] <= '0;
                                // restart policy: drop to zero and wait for a second lock
                                if (!first_lock_seen[p] && eq_ctl[p][FIRST_LOCK_BIT]) begin
                                    eq_level[p] <= 6'h00;
                                end else begin
                                    eq_state[p] <= EQ_LOCKED;
                                end
                            end else if (eq_timer[p] >= eq_limit[p] - 1'b1) begin
                                eq_timer[p] <= '0;
                                if (eq_level[p] >= {2'b00, eq_ceiling[p]}) begin
                                    eq_level[p] <= eq_start[p];
                                end else begin
                                    eq_level[p] <= eq_level[p] + 6'h01;
                                end
                            end else begin
                                eq_timer[p] <= eq_timer[p] + 1'b1;
                            end
                        end
                        EQ_LOCKED: begin
                            // lock loss resumes stepping from the level that was held
                            if (!rx_lock[p]) begin
                                eq_timer[p] <= '0;
                                eq_state[p] <= EQ_WAIT;
                            end
                        end
                        default: eq_state[p] <= EQ_START;
                    endcase
                end
            end
        end
    end

endmodule : rxeq_regs

`default_nettype wire
